// [hw/idio_pkg.sv]
// Package for the isolated digital I/O port: register map, reset values, carriers.
// Assumes a 32-bit APB register bus and one 40 MHz core clock.
package idio_pkg;
   localparam int IDIO_CH = 32;
   localparam int IDIO_AW = 6;
   // Register byte offsets
   localparam logic [IDIO_AW-1:0] IDIO_OFS_IN_DATA = 6'h00;
   localparam logic [IDIO_AW-1:0] IDIO_OFS_OUT_DATA = 6'h04;
   localparam logic [IDIO_AW-1:0] IDIO_OFS_IRQ_STAT = 6'h08;
   localparam logic [IDIO_AW-1:0] IDIO_OFS_IRQ_MASK = 6'h0c;
   localparam logic [IDIO_AW-1:0] IDIO_OFS_EDGE_SEL = 6'h10;
   localparam logic [IDIO_AW-1:0] IDIO_OFS_FILT_CFG = 6'h14;
   // Reset values
   localparam logic [31:0] IDIO_RST_OUT = 32'h0000_0000;
   localparam logic [31:0] IDIO_RST_MASK = 32'h0000_0000;
   localparam logic [31:0] IDIO_RST_EDGE = 32'h0000_0000;
   localparam logic [15:0] IDIO_RST_FILT = 16'h0000;
   // Filter tick base time and its cycle count at 40 MHz
   localparam int IDIO_CLK_MHZ = 40;
   localparam int IDIO_TICK_NS = 1000;
   localparam int IDIO_TICK_CYC = (IDIO_TICK_NS * IDIO_CLK_MHZ) / 1000;
   localparam logic [5:0] IDIO_TICK_LAST = 6'(IDIO_TICK_CYC - 1);

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [IDIO_AW-1:0] paddr;
      logic [31:0] pwdata;
   } idio_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } idio_apb_rsp_t;

   typedef enum logic [1:0] {
      IDIO_IDLE = 2'b00,
      IDIO_ACC = 2'b01
   } idio_bus_st_t;
endpackage

// [hw/idio_port.sv]
// Isolated digital I/O port: 32 filtered inputs with edge interrupts, 32 outputs.
// Assumes APB master on core_clk, inputs already synchronous, active-low field pins.
// What this block does
// [RULE1] All 32 input interrupt flags merge into one shared interrupt line.
// [RULE2] Each input has its own interrupt enable; disabled inputs never interrupt.
// [RULE3] Software selects the triggering edge; requests come only on that edge.
// [RULE4] Rising means terminal high to low; falling means terminal low to high.
// [RULE5] Terminals use negative logic: logical 1 is low, logical 0 is high.
// [RULE6] A software-set digital filter rejects noise and chatter on every input.
// [RULE7] 32 outputs follow written data inverted; written 1 turns output on.
// [RULE8] Edge events latch in sticky flags; write one clears; line held while enabled.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module idio_port
   import idio_pkg::*;
#(
   parameter int CH = IDIO_CH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // APB slave
   input wire idio_pkg::idio_apb_req_t apb_req,
   output idio_pkg::idio_apb_rsp_t apb_rsp,
   // Field terminals, active low
   input wire logic [CH-1:0] din_n,
   output logic [CH-1:0] dout_n,
   // Interrupt
   output logic irq
);
   import idio_pkg::*;

   typedef struct packed {
      idio_bus_st_t st;
      idio_apb_rsp_t rsp;
      logic [CH-1:0] out_data;
      logic [CH-1:0] dout_n;
      logic [CH-1:0] mask;
      logic [CH-1:0] edge_sel;
      logic [15:0] filt;
      logic [5:0] pre;
      logic [CH-1:0] in_val;
      logic [CH-1:0] in_init;
      logic [CH-1:0] stat;
      logic irq;
   } idio_state_t;

   idio_state_t s_r;
   idio_state_t s_nxt;

   // Per-bit filter counters
   logic [15:0] cnt_r [CH];
   logic [15:0] cnt_nxt [CH];

   logic [CH-1:0] raw;
   logic tick;
   logic [CH-1:0] new_val;
   logic [CH-1:0] ev;
   logic wr_acc;
   logic [CH-1:0] clr;

   always_comb begin
      raw = ~din_n; // see [RULE5]
      // One-cycle filter tick from the prescaler
      tick = (s_r.pre == IDIO_TICK_LAST);
      for (int i = 0; i < CH; i++) begin
         new_val[i] = s_r.in_val[i];
         cnt_nxt[i] = cnt_r[i];
         // Value is accepted after staying stable filt+1 ticks, or at once when filt is 0
         if (raw[i] == s_r.in_val[i]) begin
            cnt_nxt[i] = 16'h0000;
         end else if (s_r.filt == 16'h0000) begin
            new_val[i] = raw[i]; // see [RULE6]
         end else if (tick) begin
            if (cnt_r[i] == s_r.filt) begin
               new_val[i] = raw[i]; // see [RULE6]
               cnt_nxt[i] = 16'h0000;
            end else begin
               cnt_nxt[i] = cnt_r[i] + 16'h0001;
            end
         end
      end
      // edge_sel 0: logical 0->1 (terminal high->low); 1: logical 1->0
      ev = s_r.in_init & (new_val ^ s_r.in_val) & ~(new_val ^ ~s_r.edge_sel); // see [RULE3], [RULE4]
      wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && s_r.st == IDIO_ACC;
      clr = (wr_acc && apb_req.paddr == IDIO_OFS_IRQ_STAT) ? apb_req.pwdata : '0;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.rsp.pready = 1'b0;
      s_nxt.rsp.pslverr = 1'b0;
      s_nxt.pre = tick ? 6'h00 : s_r.pre + 6'h01;
      s_nxt.in_val = new_val;
      s_nxt.in_init = '1;
      // Set wins over clear
      s_nxt.stat = (s_r.stat & ~clr) | ev; // see [RULE8]
      // APB slave: one wait state, answers in access phase
      case (s_r.st)
         IDIO_IDLE: begin
            if (apb_req.psel && !apb_req.penable) begin
               s_nxt.st = IDIO_ACC;
            end
         end
         IDIO_ACC: begin
            if (apb_req.psel && apb_req.penable) begin
               s_nxt.st = IDIO_IDLE;
               s_nxt.rsp.pready = 1'b1;
               s_nxt.rsp.prdata = 32'h0000_0000;
               case (apb_req.paddr)
                  IDIO_OFS_IN_DATA: s_nxt.rsp.prdata = s_r.in_val;
                  IDIO_OFS_OUT_DATA: begin
                     s_nxt.rsp.prdata = s_r.out_data;
                     if (apb_req.pwrite) begin
                        s_nxt.out_data = apb_req.pwdata;
                     end
                  end
                  IDIO_OFS_IRQ_STAT: s_nxt.rsp.prdata = s_r.stat;
                  IDIO_OFS_IRQ_MASK: begin
                     s_nxt.rsp.prdata = s_r.mask;
                     if (apb_req.pwrite) begin
                        s_nxt.mask = apb_req.pwdata; // see [RULE2]
                     end
                  end
                  IDIO_OFS_EDGE_SEL: begin
                     s_nxt.rsp.prdata = s_r.edge_sel;
                     if (apb_req.pwrite) begin
                        s_nxt.edge_sel = apb_req.pwdata; // see [RULE3]
                     end
                  end
                  IDIO_OFS_FILT_CFG: begin
                     s_nxt.rsp.prdata = {16'h0000, s_r.filt};
                     if (apb_req.pwrite) begin
                        s_nxt.filt = apb_req.pwdata[15:0]; // see [RULE6]
                     end
                  end
                  default: s_nxt.rsp.pslverr = 1'b1;
               endcase
               if (!apb_req.pwrite && apb_req.paddr == IDIO_OFS_IRQ_STAT) begin
                  s_nxt.rsp.prdata = s_r.stat;
               end
            end else begin
               s_nxt.st = IDIO_IDLE;
            end
         end
         default: s_nxt.st = IDIO_IDLE;
      endcase
      s_nxt.dout_n = ~s_nxt.out_data; // see [RULE7], [RULE5]
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask); // see [RULE1], [RULE2], [RULE8]
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.out_data <= IDIO_RST_OUT;
         s_r.dout_n <= ~IDIO_RST_OUT;
         s_r.mask <= IDIO_RST_MASK;
         s_r.edge_sel <= IDIO_RST_EDGE;
         s_r.filt <= IDIO_RST_FILT;
         s_r.st <= IDIO_IDLE;
         for (int i = 0; i < CH; i++) begin
            cnt_r[i] <= 16'h0000;
         end
      end else begin
         s_r <= s_nxt;
         for (int i = 0; i < CH; i++) begin
            cnt_r[i] <= cnt_nxt[i];
         end
      end
   end

   assign apb_rsp = s_r.rsp;
   assign dout_n = s_r.dout_n;
   assign irq = s_r.irq;
endmodule

// [tb/idio_field.sv]
// Field-side model: drives the active-low input terminals.
// Assumes the bench sets the logical input value.
`timescale 1ns/1ps
module idio_field (
   // Logical value in, terminals out
   input wire logic [31:0] lv,
   output logic [31:0] din_n
);
   assign din_n = ~lv;
endmodule

// [tb/idio_port_assertions.sv]
// Checker for idio_port: bus answer timing, output and interrupt causes.
// Assumes a bind to idio_port in the bench top.
`timescale 1ns/1ps
module idio_port_chk
   import idio_pkg::*;
#(parameter int CH = IDIO_CH) (
   // Watched ports
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire idio_pkg::idio_apb_req_t apb_req,
   input wire idio_pkg::idio_apb_rsp_t apb_rsp,
   input wire logic [CH-1:0] din_n,
   input wire logic [CH-1:0] dout_n,
   input wire logic irq
);
   logic wr;
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence acc_s; apb_req.psel && apb_req.penable; endsequence
   chk_rdy_late: assert property ($rose(apb_req.penable) ##0 acc_s |=> apb_rsp.pready)
      else $error("pready late");
   chk_rdy_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready long");
   chk_rdy_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
      else $error("pready without access");
   chk_err_zero: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("bad error answer");
   chk_out_cause:
      assert property ($changed(dout_n) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("output moved without write");
   chk_irq_fall:
      assert property ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("irq dropped without write");
   chk_irq_quiet:
      assert property ($fell(sys_rst) |-> !irq [*3]) else $error("irq with all masked");
   chk_rst_quiet:
      assert property (disable iff (1'b0) sys_rst |=> dout_n == '1 && !irq && !apb_rsp.pready)
      else $error("reset state wrong");
endmodule

// [tb/isolated_digital_io_with_irq_tb_top.sv]
// Testbench for the I/O port: registers, outputs, inputs, interrupts, filter.
// Assumes idio_pkg, the field model and the checker are compiled first.
`timescale 1ns/1ps
module isolated_digital_io_with_irq_tb_top;
   import idio_pkg::*;
   logic core_clk, sys_rst, irq, err;
   idio_apb_req_t apb_req;
   idio_apb_rsp_t apb_rsp;
   logic [31:0] lv, din_n, dout_n, rd;
   int failures, check_count;
   idio_field u_fld (.lv(lv), .din_n(din_n));
   idio_port dut (.core_clk(core_clk), .sys_rst(sys_rst), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .din_n(din_n), .dout_n(dout_n), .irq(irq));
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(logic w, logic [5:0] a, logic [31:0] d);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      apb_req.penable <= 1'b1;
      do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge core_clk);
   endtask
   task automatic set_in(logic [31:0] v, int n);
      lv <= v;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic t_out();
      apb(0, IDIO_OFS_OUT_DATA, 0);
      chk("out_rst", rd, IDIO_RST_OUT);
      chk("dout_rst", dout_n, '1);
      apb(1, IDIO_OFS_OUT_DATA, 32'h8000_0f01);
      set_in(0, 2);
      chk("dout", dout_n, 32'h7fff_f0fe);
      apb(0, 6'h3c, 0);
      chk("bad_err", {31'h0, err}, 32'h1);
   endtask
   task automatic t_in();
      set_in(32'h0000_00f0, 4);
      apb(0, IDIO_OFS_IN_DATA, 0);
      chk("in", rd, 32'h0000_00f0);
      apb(0, IDIO_OFS_IRQ_STAT, 0);
      chk("stat", rd, 32'h0000_00f0);
      chk("irq_off", {31'h0, irq}, 32'h0);
      apb(1, IDIO_OFS_IRQ_STAT, 32'hff);
      set_in(0, 4);
      apb(0, IDIO_OFS_IRQ_STAT, 0);
      chk("stat_fall", rd, 32'h0);
   endtask
   task automatic t_irq();
      apb(1, IDIO_OFS_IRQ_MASK, 32'h5);
      apb(1, IDIO_OFS_EDGE_SEL, 32'h4);
      set_in(32'h4, 4);
      chk("irq_edge", {31'h0, irq}, 32'h0);
      set_in(32'h5, 4);
      chk("irq_on", {31'h0, irq}, 32'h1);
      set_in(32'h1, 4);
      apb(0, IDIO_OFS_IRQ_STAT, 0);
      chk("stat_both", rd, 32'h5);
      apb(1, IDIO_OFS_IRQ_STAT, 32'h1);
      chk("irq_hold", {31'h0, irq}, 32'h1);
      apb(1, IDIO_OFS_IRQ_STAT, 32'h4);
      set_in(32'h1, 2);
      chk("irq_clr", {31'h0, irq}, 32'h0);
   endtask
   task automatic t_filt();
      apb(1, IDIO_OFS_FILT_CFG, 32'h1);
      set_in(32'h9, 40);
      set_in(32'h1, 100);
      apb(0, IDIO_OFS_IN_DATA, 0);
      chk("filt_rej", rd, 32'h1);
      set_in(32'h9, 130);
      apb(0, IDIO_OFS_IN_DATA, 0);
      chk("filt_ok", rd, 32'h9);
   endtask
   initial begin
      #200us;
      failures++;
      print_verdict();
   end
   initial begin
      sys_rst = 1'b1;
      apb_req = '0;
      lv = '0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      t_out();
      t_in();
      t_irq();
      t_filt();
      print_verdict();
   end
endmodule
bind idio_port idio_port_chk #(.CH(CH)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .din_n(din_n), .dout_n(dout_n), .irq(irq));
